// ===== src/tal_top.sv
// Temperature alert block: APB registers, pointer reads and the over-temperature pin.
`timescale 1ns/10ps
`include "tal_cfg.svh"

// What this block does
// (RQ1) Configuration register reads back as one byte.
// (RQ2) Temperature reads as two bytes, high first.
// (RQ3) Pointer write selects the register then read.
// (RQ4) Pin powers up inactive: high, with active-low polarity.
// (RQ5) Comparator mode after reset; interrupt when configured.
// (RQ6) Comparator: active at temperature at or above trip.
// (RQ7) Comparator: inactive only below release limit.
// (RQ8) Shutdown keeps the comparator output state.
// (RQ9) Interrupt: active after configured consecutive faults.
// (RQ10) Interrupt: completed register read clears output.
// (RQ11) After clear, reassert only on new trip.
// (RQ12) Signed compare once per conversion; count faults.
// (RQ13) Queue code gives 1, 2, 4, 6 faults.
// (RQ14) Polarity bit: 0 active low, 1 high.
// (RQ15) Mode bit: 0 comparator, 1 interrupt.
// (RQ16) Shutdown bit halts conversions; serial side works.
module tal_top
   import tal_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] temp_value,
   input  wire logic        temp_done,
   output logic             overtemp_output_pin,
   output logic             irq
);

   // ****************************************************************
   // State and decode
   // ****************************************************************
   tal_top_s   q;
   tal_top_s   d;
   logic       setup;
   logic       acc;
   logic       wr;
   logic       rd;
   logic       eval;
   logic       rd_byte;
   logic       ptr_wr;
   logic       byte_done;
   logic       word_done;
   logic       alert_clear;
   logic       active;
   logic       fire;
   logic [7:0] byte_rd;

   function automatic logic tal_mapped(input logic [7:0] a);
      case (a)
         `TAL_OFF_PTR, `TAL_OFF_DATA, `TAL_OFF_CONF, `TAL_OFF_TRIP, `TAL_OFF_REL,
         `TAL_OFF_TEMP, `TAL_OFF_IRQ_ST, `TAL_OFF_IRQ_MASK, `TAL_OFF_STATE:
            tal_mapped = 1'b1;
         default:
            tal_mapped = 1'b0;
      endcase
   endfunction

   // The answer is registered from the setup cycle, so every transfer ends in its
   // first access cycle while read data and the error flag leave from flip-flops.
   assign setup   = psel && !penable;
   assign acc     = psel && penable && q.pready;
   assign wr      = acc && pwrite && tal_mapped(paddr);
   assign rd      = acc && !pwrite && tal_mapped(paddr);
   assign ptr_wr  = wr && paddr == `TAL_OFF_PTR;                      // [RQ3]
   assign rd_byte = rd && paddr == `TAL_OFF_DATA;

   // A whole word read of a configuration, temperature or limit register also counts as a
   // completed read, so software on the parallel bus can clear the pin too.
   assign word_done = rd && (paddr == `TAL_OFF_CONF || paddr == `TAL_OFF_TRIP ||
                             paddr == `TAL_OFF_REL || paddr == `TAL_OFF_TEMP);
   assign alert_clear = (byte_done || word_done) && q.conf[`TAL_CFG_MODE]; // [RQ10] [RQ15]

   // Shutdown drops the conversion results but leaves the pin as it was.
   assign eval = temp_done && !q.conf[`TAL_CFG_SHDN];                 // [RQ16] [RQ8]

   // ****************************************************************
   // Submodules
   // ****************************************************************
   tal_byte_reader u_reader (
      .pclk    (pclk),
      .presetn (presetn),
      .ptr_wr  (ptr_wr),
      .rd      (rd_byte),
      .ptr     (q.ptr),
      .conf    (q.conf),
      .temp    (q.temp),
      .lim     (q.lim),
      .byte_o  (byte_rd),
      .done    (byte_done)
   );

   tal_alert_eval u_eval (
      .pclk     (pclk),
      .presetn  (presetn),
      .eval     (eval),
      .clear    (alert_clear),
      .mode_int (q.conf[`TAL_CFG_MODE]),                              // [RQ5] [RQ15]
      .queue    (q.conf[`TAL_CFG_FQ_HI:`TAL_CFG_FQ_LO]),              // [RQ13]
      .lim      (q.lim),
      // The fresh result is judged at the edge that stores it, not the stored one.
      .temp     (temp_value),                                         // [RQ12]
      .active   (active),
      .fire     (fire)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      d         = q;
      d.pready  = setup;
      d.pslverr = setup && !tal_mapped(paddr);
      if (setup) begin
         case (paddr)
            `TAL_OFF_PTR:      d.prdata = {30'h0, q.ptr};
            `TAL_OFF_DATA:     d.prdata = {24'h0, byte_rd};           // [RQ1] [RQ2]
            `TAL_OFF_CONF:     d.prdata = {24'h0, q.conf};
            `TAL_OFF_TRIP:     d.prdata = {16'h0, q.lim.trip};
            `TAL_OFF_REL:      d.prdata = {16'h0, q.lim.rel};
            `TAL_OFF_TEMP:     d.prdata = {16'h0, q.temp};
            `TAL_OFF_IRQ_ST:   d.prdata = {30'h0, q.irq_st};
            `TAL_OFF_IRQ_MASK: d.prdata = {30'h0, q.irq_mask};
            `TAL_OFF_STATE:    d.prdata = {31'h0, active};
            default:           d.prdata = 32'h0;
         endcase
      end

      if (wr) begin
         case (paddr)
            `TAL_OFF_PTR:      d.ptr = pwdata[1:0];                   // [RQ3]
            `TAL_OFF_CONF:     d.conf = pwdata[7:0];                  // [RQ14] [RQ15] [RQ16]
            `TAL_OFF_TRIP:     d.lim.trip = pwdata[15:0];
            `TAL_OFF_REL:      d.lim.rel = pwdata[15:0];
            `TAL_OFF_IRQ_MASK: d.irq_mask = pwdata[`TAL_IRQ_W-1:0];
            default:           d.ptr = q.ptr;
         endcase
      end

      if (eval) begin
         d.temp = temp_value;                                         // [RQ12]
      end

      // Read clears the sticky bits; an event in the same cycle still lands.
      if (rd && paddr == `TAL_OFF_IRQ_ST) begin
         d.irq_st = '0;
      end
      d.irq_st[`TAL_IRQ_FIRE] = d.irq_st[`TAL_IRQ_FIRE] | fire;
      d.irq_st[`TAL_IRQ_CONV] = d.irq_st[`TAL_IRQ_CONV] | eval;
      d.irq = |(q.irq_st & q.irq_mask);

      // The pin shows the alert state, in the level the polarity bit selects.
      d.pin = q.conf[`TAL_CFG_POL] ? active : !active;                // [RQ4] [RQ14] [RQ6]
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q          <= '0;
         q.conf     <= `TAL_CONF_RST;                                 // [RQ5]
         q.lim.trip <= `TAL_TRIP_RST;
         q.lim.rel  <= `TAL_REL_RST;
         q.temp     <= `TAL_TEMP_RST;
         q.ptr      <= `TAL_PTR_TEMP;
         q.pin      <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign prdata              = q.prdata;
   assign pready              = q.pready;
   assign pslverr             = q.pslverr;
   assign overtemp_output_pin = q.pin;
   assign irq                 = q.irq;

endmodule // tal_top

// ===== src/tal_cfg.svh
// Offsets, field positions, reset values and codes of the temperature alert block.
`ifndef TAL_CFG_SVH
`define TAL_CFG_SVH

// ****************************************************************
// APB register byte offsets
// ****************************************************************
`define TAL_OFF_PTR       8'h00
`define TAL_OFF_DATA      8'h04
`define TAL_OFF_CONF      8'h08
`define TAL_OFF_TRIP      8'h0c
`define TAL_OFF_REL       8'h10
`define TAL_OFF_TEMP      8'h14
`define TAL_OFF_IRQ_ST    8'h18
`define TAL_OFF_IRQ_MASK  8'h1c
`define TAL_OFF_STATE     8'h20

// ****************************************************************
// Pointer codes
// ****************************************************************
`define TAL_PTR_TEMP      2'h0
`define TAL_PTR_CONF      2'h1
`define TAL_PTR_REL       2'h2
`define TAL_PTR_TRIP      2'h3

// ****************************************************************
// Configuration fields and reset values
// ****************************************************************
`define TAL_CFG_SHDN      0
`define TAL_CFG_MODE      1
`define TAL_CFG_POL       2
`define TAL_CFG_FQ_LO     3
`define TAL_CFG_FQ_HI     4
`define TAL_CONF_RST      8'h00
`define TAL_TRIP_RST      16'h5000
`define TAL_REL_RST       16'h4b00
`define TAL_TEMP_RST      16'h0000

// ****************************************************************
// Fault queue lengths per code
// ****************************************************************
`define TAL_FQ_CODE1      2'h0
`define TAL_FQ_CODE2      2'h1
`define TAL_FQ_CODE4      2'h2
`define TAL_FQ_N1         3'h1
`define TAL_FQ_N2         3'h2
`define TAL_FQ_N4         3'h4
`define TAL_FQ_N6         3'h6

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define TAL_IRQ_FIRE      0
`define TAL_IRQ_CONV      1
`define TAL_IRQ_W         2

`endif

// ===== src/tal_pkg.sv
// Types shared by the temperature alert block.
package tal_pkg;

   typedef struct packed {
      logic [15:0] trip;
      logic [15:0] rel;
   } tal_limits_s;

   typedef struct packed {
      logic       active;
      logic [2:0] cnt;
   } tal_eval_s;

   typedef enum logic [0:0] {TAL_PH_FIRST, TAL_PH_SECOND} tal_phase_e;

   typedef struct packed {
      tal_phase_e phase;
   } tal_rd_s;

   typedef struct packed {
      logic [1:0]  ptr;
      logic [7:0]  conf;
      tal_limits_s lim;
      logic [15:0] temp;
      logic [1:0]  irq_st;
      logic [1:0]  irq_mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        pin;
      logic        irq;
   } tal_top_s;

endpackage

// ===== src/tal_alert_eval.sv
// Over-temperature evaluation with fault queue, comparator and interrupt behaviour.
`timescale 1ns/10ps
`include "tal_cfg.svh"
module tal_alert_eval
   import tal_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        eval,
   input  wire logic        clear,
   input  wire logic        mode_int,
   input  wire logic [1:0]  queue,
   input  wire tal_limits_s lim,
   input  wire logic [15:0] temp,
   output logic             active,
   output logic             fire
);

   tal_eval_s q;
   tal_eval_s d;
   logic      over;
   logic [2:0] base;
   logic [2:0] need;

   function automatic logic [2:0] tal_need(input logic [1:0] code);
      case (code)
         `TAL_FQ_CODE1: tal_need = `TAL_FQ_N1;
         `TAL_FQ_CODE2: tal_need = `TAL_FQ_N2;
         `TAL_FQ_CODE4: tal_need = `TAL_FQ_N4;
         default:       tal_need = `TAL_FQ_N6;
      endcase
   endfunction

   always_comb begin
      d    = q;
      fire = 1'b0;
      need = tal_need(queue);                                        // [RQ13]
      over = $signed(temp) >= $signed(lim.trip);                     // [RQ12]
      base = q.cnt;
      // A clear restarts the queue, so only fresh over-limit results re-trigger.
      if (clear) begin
         d.active = 1'b0;                                            // [RQ10]
         base     = 3'h0;                                            // [RQ11]
      end
      d.cnt = base;
      if (eval) begin
         if (over) begin
            // The count runs on to the longest queue, so a longer queue chosen
            // while hot still sees every consecutive fault.
            d.cnt = (base >= `TAL_FQ_N6) ? base : base + 3'h1;       // [RQ12]
            // Setting wins over a clear in the same cycle only for a one-fault queue, as the clear restarts the count.
            if (d.cnt >= need && !d.active) begin                    // [RQ6] [RQ9]
               d.active = 1'b1;
               fire     = 1'b1;
            end
         end else begin
            d.cnt = 3'h0;                                            // [RQ12]
            if (!mode_int && $signed(temp) < $signed(lim.rel)) begin
               d.active = 1'b0;                                      // [RQ7]
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign active = q.active;

endmodule // tal_alert_eval

// ===== src/tal_byte_reader.sv
// Byte-wise register read through the pointer: one byte or two bytes high first.
`timescale 1ns/10ps
`include "tal_cfg.svh"
module tal_byte_reader
   import tal_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ptr_wr,
   input  wire logic        rd,
   input  wire logic [1:0]  ptr,
   input  wire logic [7:0]  conf,
   input  wire logic [15:0] temp,
   input  wire tal_limits_s lim,
   output logic [7:0]       byte_o,
   output logic             done
);

   tal_rd_s    q;
   tal_rd_s    d;
   logic [15:0] word;

   always_comb begin
      d    = q;
      done = 1'b0;
      case (ptr)                                                     // [RQ3]
         `TAL_PTR_TEMP: word = temp;
         `TAL_PTR_REL:  word = lim.rel;
         `TAL_PTR_TRIP: word = lim.trip;
         default:       word = {8'h00, conf};
      endcase
      if (ptr == `TAL_PTR_CONF) begin
         byte_o = conf;                                              // [RQ1]
      end else if (q.phase == TAL_PH_FIRST) begin
         byte_o = word[15:8];                                        // [RQ2]
      end else begin
         byte_o = word[7:0];                                         // [RQ2]
      end
      if (ptr_wr) begin
         d.phase = TAL_PH_FIRST;
      end else if (rd) begin
         if (ptr == `TAL_PTR_CONF || q.phase == TAL_PH_SECOND) begin
            d.phase = TAL_PH_FIRST;
            done    = 1'b1;
         end else begin
            d.phase = TAL_PH_SECOND;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{phase: TAL_PH_FIRST};
      end else begin
         q <= d;
      end
   end

endmodule // tal_byte_reader

// ===== dv/tal_apb_mst.sv
// APB master model standing in for the bus master of the alert block.
`timescale 1ns/10ps
module tal_apb_mst (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic [31:0] rdat;
   logic        rerr;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // ********
   // One transfer, held until pready is seen at a rising edge
   // ********
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      // Released lines show a changed value, so no stale data can pass for a hold.
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
endmodule // tal_apb_mst

// ===== dv/tal_chk.sv
// Assertions on the ports of the temperature alert block.
`timescale 1ns/10ps
`include "tal_cfg.svh"
module tal_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] temp_value,
   input wire logic        temp_done,
   input wire logic        overtemp_output_pin,
   input wire logic        irq
);
   logic [7:0]  conf_q;
   logic [15:0] trip_q;
   logic [15:0] rel_q;
   logic        cmp;
   logic        pol;
   // Own copy of the settings, so a write lost inside the design still shows.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conf_q <= `TAL_CONF_RST;
         trip_q <= `TAL_TRIP_RST;
         rel_q <= `TAL_REL_RST;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == `TAL_OFF_CONF) conf_q <= pwdata[7:0];
         if (paddr == `TAL_OFF_TRIP) trip_q <= pwdata[15:0];
         if (paddr == `TAL_OFF_REL) rel_q <= pwdata[15:0];
      end
   end
   assign pol = conf_q[`TAL_CFG_POL];
   assign cmp = temp_done && !psel && conf_q[1:0] == 2'h0;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ********
   // Properties
   // ********
   property p_rst; $rose(presetn) |-> overtemp_output_pin && !irq && !pready; endproperty
   a_rst: assert property (p_rst) else $error("bad outputs after reset");
   property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready not one access cycle");
   property p_err; psel && penable && paddr >= 8'h24 |-> pslverr && pready; endproperty
   a_err: assert property (p_err) else $error("no error on unmapped address");
   property p_hi;
      cmp && conf_q[4:3] == 2'h0 && $signed(temp_value) >= $signed(trip_q)
         |-> ##2 overtemp_output_pin == pol;
   endproperty
   a_hi: assert property (p_hi) else $error("pin not active at trip");
   property p_lo;
      cmp && $signed(temp_value) < $signed(rel_q) && $signed(temp_value) < $signed(trip_q)
         |-> ##2 overtemp_output_pin != pol;
   endproperty
   a_lo: assert property (p_lo) else $error("pin not released below limit");
   property p_sd;
      conf_q[0] && temp_done && !psel |-> ##2 overtemp_output_pin == $past(overtemp_output_pin, 2);
   endproperty
   a_sd: assert property (p_sd) else $error("pin moved in shutdown");
   property p_irq; $rose(irq) |-> $past(temp_done, 2) || $past(psel) || $past(psel, 2); endproperty
   a_irq: assert property (p_irq) else $error("irq rose without cause");
   property p_clr;
      psel && penable && pready && !pwrite && paddr == `TAL_OFF_TEMP && conf_q[1] && !temp_done
         |=> ##1 overtemp_output_pin != pol;
   endproperty
   a_clr: assert property (p_clr) else $error("read did not clear pin");
endmodule // tal_chk

bind tal_top tal_chk tal_chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .temp_value(temp_value), .temp_done(temp_done),
   .overtemp_output_pin(overtemp_output_pin), .irq(irq)
);

// ===== dv/tb.sv
// Bench of the temperature alert block against a behavioural model.
`timescale 1ns/10ps
`include "tal_cfg.svh"
module tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, pin, irq;
   logic        temp_done = 1'b0;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] temp_value = 16'h0;
   logic [7:0]  conf = `TAL_CONF_RST;
   logic [15:0] trip = `TAL_TRIP_RST, rel = `TAL_REL_RST, tmp = `TAL_TEMP_RST;
   logic [1:0]  st = 2'h0, mask = 2'h0, p;
   logic        act = 1'b0;
   int          cnt = 0, n_fail = 0, n_checks = 0;
   int          qn[4] = '{1, 2, 4, 6};
   logic [15:0] vals[4] = '{16'h5000, 16'h4fff, 16'h4aff, 16'h6400};
   logic [7:0]  ra[7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
   logic [31:0] rv[7] = '{32'h0, 32'h5000, 32'h4b00, 32'h0, 32'h0, 32'h0, 32'h0};
   always #10 pclk = ~pclk;
   tal_top tal_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .temp_value(temp_value), .temp_done(temp_done),
      .overtemp_output_pin(pin), .irq(irq));
   tal_apb_mst tal_apb_mst_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ********
   // Checks and model
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pinchk;
      chk({31'h0, pin}, {31'h0, act ? conf[2] : !conf[2]});
      chk({31'h0, irq}, {31'h0, |(st & mask)});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      tal_apb_mst_i.xfer(1'b1, a, d);
      if (a == 8'h08) conf = d[7:0];
      if (a == 8'h0c) trip = d[15:0];
      if (a == 8'h10) rel = d[15:0];
      if (a == 8'h1c) mask = d[1:0];
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit last);
      tal_apb_mst_i.xfer(1'b0, a, 32'h0);
      chk(tal_apb_mst_i.rdat, e);
      chk({31'h0, tal_apb_mst_i.rerr}, {31'h0, a > 8'h20});
      if (a == 8'h18) st = 2'h0;
      if (conf[1] && (a inside {8'h08, 8'h0c, 8'h10, 8'h14} || (a == 8'h04 && last))) begin
         act = 1'b0;
         cnt = 0;
      end
      repeat (2) @(posedge pclk);
      pinchk();
   endtask
   task automatic rdp(input logic [1:0] q, input logic [15:0] v);
      wr(8'h00, {30'h0, q});
      if (q != `TAL_PTR_CONF) rd(8'h04, {24'h0, v[15:8]}, 1'b0);
      rd(8'h04, {24'h0, v[7:0]}, 1'b1);
   endtask
   task automatic conv(input logic [15:0] v);
      temp_value <= v;
      temp_done <= 1'b1;
      @(posedge pclk);
      temp_done <= 1'b0;
      if (!conf[0]) begin
         tmp = v;
         st[1] = 1'b1;
         if ($signed(v) >= $signed(trip)) begin
            cnt++;
            if (!act && cnt >= qn[conf[4:3]]) begin
               act = 1'b1;
               st[0] = 1'b1;
            end
         end else begin
            cnt = 0;
            if (!conf[1] && $signed(v) < $signed(rel)) act = 1'b0;
         end
      end
      repeat (3) @(posedge pclk);
      pinchk();
   endtask
   task automatic conclude;
      $display("Checks %0d, errors %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      conclude();
   end
   initial begin
      void'($urandom(32'he62f));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      pinchk();
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i], 1'b0);
      rd(8'h40, 32'h0, 1'b0);
      wr(8'h1c, 32'h3);
      conv(16'h5000);
      conv(16'h4b00);
      conv(16'h4aff);
      conv(16'hff00);
      rd(8'h18, 32'h3, 1'b0);
      conv(16'h7f00);
      wr(8'h08, 32'h1);
      conv(16'h0000);
      rd(8'h14, 32'h7f00, 1'b0);
      rd(8'h20, 32'h1, 1'b0);
      // Every queue, polarity and mode code, with random temperatures and reads.
      for (int c = 0; c < 16; c++) begin
         wr(8'h08, {27'h0, c[3:2], c[0], c[1], 1'b0});
         for (int k = 0; k < 10; k++) begin
            conv(vals[$urandom_range(3)]);
            p = 2'($urandom_range(3));
            if ($urandom_range(2) == 0) rdp(p, p == 0 ? tmp : p == 1 ? {8'h0, conf} :
               p == 2 ? rel : trip);
            else if ($urandom_range(1) == 0) rd(`TAL_OFF_TEMP, {16'h0, tmp}, 1'b0);
         end
      end
      conclude();
   end
endmodule // tb
